//--- hw/cfs_map.vh
// Behaviour
// - gain and residual from host or strap
// - host lockout threshold 4.18-16 V, inhibit below
// - strap lockout: 4.5 V low, 10.8 V upper codes
// - host-programmable input undervoltage response
// - retry: shut down, recheck input every 70ms
// - restart above warning level, default 1.05x
// - no retry as current sharing member
// - address strap: 19h-37h, open 28h, ground 26h
// - overvoltage threshold default 15% above target
// - overvoltage: latch off, or 70ms retry
// - sample output before any ramp
// - prebias below: start from prebias, then ramp
// - below case reaches target after ramp time
// - prebias above: target equals prebias, drivers on
// - above case: good after ramp, then down
// - prebias over limit: skip start, overvoltage fault
`ifndef CFS_MAP_VH
`define CFS_MAP_VH
`define CFS_CTRL          8'h00
`define CFS_LOOP_GAIN_CFG 8'h04
`define CFS_IN_LO_FAULT   8'h08
`define CFS_IN_LO_WARN    8'h0c
`define CFS_IN_LO_ACTION  8'h10
`define CFS_OUT_HI_FAULT  8'h14
`define CFS_OUT_HI_ACTION 8'h18
`define CFS_VOUT_TARGET   8'h1c
`define CFS_TIMING        8'h20
`define CFS_STATUS        8'h24
`define CFS_IRQ_STAT      8'h28
`define CFS_IRQ_MASK      8'h2c
`define CFS_STRAP         8'h30
`define CFS_VALID_BIT     16
`define CFS_VOUT_RST      16'h03e8
`define CFS_DELAY_RST     16'h0005
`define CFS_RAMP_RST      16'h0005
`define CFS_INPUT_LOCKOUT_LO_MV    16'h1194
`define CFS_INPUT_LOCKOUT_HI_MV    16'h2a30
`define CFS_INPUT_LOCKOUT_MIN_MV   16'h1054
`define CFS_INPUT_LOCKOUT_MAX_MV   16'h3e80
`define CFS_ADDR_BASE     7'h19
`define CFS_ADDR_MAX      7'h37
`define CFS_ADDR_OPEN     7'h28
`define CFS_ADDR_GND      7'h26
`define CFS_RES_LO        7'h5a
`define CFS_RES_HI        7'h64
`define CFS_ACT_LATCH     2'h0
`define CFS_ACT_RETRY     2'h1
`define CFS_ACT_IGNORE    2'h2
`define CFS_CLK_HZ        100000000
`define CFS_RETRY_MS      70
`define CFS_IRQ_UV        0
`define CFS_IRQ_OV        1
`define CFS_IRQ_PG        2
`define CFS_IRQ_RESTART   3
`endif

//--- hw/cfs_supervisor.v
`timescale 1ns/1ps
`include "cfs_map.vh"
module cfs_supervisor #(
	parameter MS_CYCLES    = `CFS_CLK_HZ / 1000,
	parameter RETRY_CYCLES = `CFS_RETRY_MS * MS_CYCLES
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        enable_in,
	input  wire [15:0] vin_mv,
	input  wire [15:0] vout_sense_mv,
	input  wire [4:0]  loop_gain_strap_code,
	input  wire [3:0]  softstart_lockout_strap_code,
	input  wire [4:0]  bus_address_strap_code,
	input  wire        bus_address_strap_open,
	input  wire        bus_address_strap_gnd,
	output reg         power_good_output,
	output reg         driver_enable,
	output reg  [15:0] target_mv,
	output reg  [9:0]  loop_gain_value,
	output reg  [6:0]  loop_residual,
	output reg  [6:0]  bus_address,
	output reg         irq
);
	localparam [5:0] S_OFF = 6'h01, S_DELAY = 6'h02, S_RAMP = 6'h04;
	localparam [5:0] S_ON = 6'h08, S_RETRY = 6'h10, S_LATCH = 6'h20;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	function [9:0] gain_of;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: gain_of = 10'h050;
				4'h1: gain_of = 10'h078;
				4'h2: gain_of = 10'h0a0;
				4'h3: gain_of = 10'h0c8;
				4'h4: gain_of = 10'h0f0;
				4'h5: gain_of = 10'h118;
				4'h6: gain_of = 10'h140;
				4'h7: gain_of = 10'h168;
				4'h8: gain_of = 10'h190;
				4'h9: gain_of = 10'h1c2;
				4'ha: gain_of = 10'h1f4;
				4'hb: gain_of = 10'h226;
				4'hc: gain_of = 10'h258;
				4'hd: gain_of = 10'h2bc;
				default: gain_of = 10'h320;
			endcase
		end
	endfunction

	reg  [31:0] ctrl_ff, gain_cfg_ff, uv_lim_ff, uv_warn_ff, uv_act_ff;
	reg  [31:0] ov_lim_ff, ov_act_ff, vtgt_ff, timing_ff, irq_stat_ff, irq_mask_ff;
	reg  [7:0]  aw_addr_ff;
	reg         aw_got_ff, w_got_ff;
	reg  [31:0] w_data_ff;
	reg  [3:0]  w_strb_ff;
	reg         strap_done_ff;
	reg  [4:0]  st_gain_ff;
	reg         st_uv_hi_ff;
	reg  [5:0]  state_ff, nxt_state;
	reg  [39:0] cnt_ff, nxt_cnt;
	reg  [39:0] acc_ff, nxt_acc;
	reg  [15:0] nxt_target;
	reg  [15:0] span_ff, nxt_span;
	reg         up_ff, nxt_up;
	reg         cause_ov_ff, nxt_cause_ov;
	reg         nxt_pg, nxt_drv;
	reg  [3:0]  ev;

	wire        aw_hs = s_axi_awvalid & s_axi_awready;
	wire        w_hs  = s_axi_wvalid & s_axi_wready;
	wire        do_wr = aw_got_ff & w_got_ff & ~s_axi_bvalid;
	wire [3:0]  widx  = aw_addr_ff[5:2];
	wire        wmap  = (aw_addr_ff[7:6] == 2'b00) && (aw_addr_ff[5:2] <= 4'hc)
				&& (aw_addr_ff[1:0] == 2'b00);

	wire        member   = ctrl_ff[1];
	wire        host_en  = ctrl_ff[0];
	wire [15:0] final_mv = vtgt_ff[15:0];
	// host values win once written, straps fill in otherwise
	wire [15:0] input_lockout_mv  = uv_lim_ff[`CFS_VALID_BIT] ? uv_lim_ff[15:0] :
				(st_uv_hi_ff ? `CFS_INPUT_LOCKOUT_HI_MV : `CFS_INPUT_LOCKOUT_LO_MV);
	wire [16:0] warn_def = {1'b0, input_lockout_mv} + {1'b0, input_lockout_mv} / 17'd20;
	wire [16:0] warn_mv  = uv_warn_ff[`CFS_VALID_BIT] ? {1'b0, uv_warn_ff[15:0]} : warn_def;
	wire [17:0] ov_def   = {2'b00, final_mv} + ({2'b00, final_mv} * 18'd3) / 18'd20;
	wire [17:0] ov_mv    = ov_lim_ff[`CFS_VALID_BIT] ? {2'b00, ov_lim_ff[15:0]} : ov_def;
	wire        uv_low   = vin_mv < input_lockout_mv;
	wire        ov_high  = {2'b00, vout_sense_mv} > ov_mv;
	wire [39:0] delay_n  = {24'h0, timing_ff[15:0]} * {8'h0, MS_CYCLES[31:0]};
	wire [39:0] ramp_n   = {24'h0, timing_ff[31:16]} * {8'h0, MS_CYCLES[31:0]};
	wire [39:0] retry_n  = {8'h0, RETRY_CYCLES[31:0]};
	wire [39:0] delta    = up_ff ? {24'h0, span_ff} : 40'h0;
	wire [3:0]  gain_idx = gain_cfg_ff[8] ? gain_cfg_ff[3:0] :
				(st_gain_ff >= 5'd15 ? st_gain_ff[3:0] - 4'd15 + 4'd0 : st_gain_ff[3:0]);
	wire        res_hi   = gain_cfg_ff[8] ? gain_cfg_ff[4] : (st_gain_ff >= 5'd15);

	// clamp host lockout writes into the legal window
	wire [31:0] uv_wr    = merge(uv_lim_ff, w_data_ff, w_strb_ff);
	wire [15:0] uv_clamp = uv_wr[15:0] < `CFS_INPUT_LOCKOUT_MIN_MV ? `CFS_INPUT_LOCKOUT_MIN_MV :
				(uv_wr[15:0] > `CFS_INPUT_LOCKOUT_MAX_MV ? `CFS_INPUT_LOCKOUT_MAX_MV : uv_wr[15:0]);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h0000_0000;
			w_strb_ff     <= 4'h0;
			ctrl_ff       <= 32'h0000_0000;
			gain_cfg_ff   <= 32'h0000_0000;
			uv_lim_ff     <= 32'h0000_0000;
			uv_warn_ff    <= 32'h0000_0000;
			uv_act_ff     <= 32'h0000_0000;
			ov_lim_ff     <= 32'h0000_0000;
			ov_act_ff     <= 32'h0000_0000;
			vtgt_ff       <= {16'h0000, `CFS_VOUT_RST};
			timing_ff     <= {`CFS_RAMP_RST, `CFS_DELAY_RST};
			irq_stat_ff   <= 32'h0000_0000;
			irq_mask_ff   <= 32'h0000_0000;
		end else begin
			if (aw_hs) begin
				aw_addr_ff    <= s_axi_awaddr;
				aw_got_ff     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				w_data_ff    <= s_axi_wdata;
				w_strb_ff    <= s_axi_wstrb;
				w_got_ff     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wmap ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (do_wr && wmap) begin
				case (widx)
					4'h0: ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff) & 32'h3;
					4'h1: gain_cfg_ff <= merge(gain_cfg_ff, w_data_ff, w_strb_ff) & 32'h11f;
					4'h2: uv_lim_ff <= {uv_wr[31:16] & 16'h0001, uv_clamp};
					4'h3: uv_warn_ff <= merge(uv_warn_ff, w_data_ff, w_strb_ff) & 32'h1ffff;
					4'h4: uv_act_ff <= merge(uv_act_ff, w_data_ff, w_strb_ff) & 32'h3;
					4'h5: ov_lim_ff <= merge(ov_lim_ff, w_data_ff, w_strb_ff) & 32'h1ffff;
					4'h6: ov_act_ff <= merge(ov_act_ff, w_data_ff, w_strb_ff) & 32'h1;
					4'h7: vtgt_ff <= merge(vtgt_ff, w_data_ff, w_strb_ff) & 32'hffff;
					4'h8: timing_ff <= merge(timing_ff, w_data_ff, w_strb_ff);
					4'hb: irq_mask_ff <= merge(irq_mask_ff, w_data_ff, w_strb_ff) & 32'hf;
					default: ;
				endcase
			end
			// a new event beats a write-one-to-clear in the same cycle
			irq_stat_ff <= (irq_stat_ff & ~((do_wr && wmap && widx == 4'ha) ?
				(w_data_ff & {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
				{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}}) : 32'h0)) | {28'h0, ev};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'b00;
			case (s_axi_araddr)
				`CFS_CTRL:          s_axi_rdata <= ctrl_ff;
				`CFS_LOOP_GAIN_CFG: s_axi_rdata <= gain_cfg_ff;
				`CFS_IN_LO_FAULT:   s_axi_rdata <= uv_lim_ff;
				`CFS_IN_LO_WARN:    s_axi_rdata <= uv_warn_ff;
				`CFS_IN_LO_ACTION:  s_axi_rdata <= uv_act_ff;
				`CFS_OUT_HI_FAULT:  s_axi_rdata <= ov_lim_ff;
				`CFS_OUT_HI_ACTION: s_axi_rdata <= ov_act_ff;
				`CFS_VOUT_TARGET:   s_axi_rdata <= vtgt_ff;
				`CFS_TIMING:        s_axi_rdata <= timing_ff;
				`CFS_STATUS:        s_axi_rdata <= {target_mv, 4'h0, cause_ov_ff, ov_high,
						uv_low, driver_enable, power_good_output, 1'b0, state_ff};
				`CFS_IRQ_STAT:      s_axi_rdata <= irq_stat_ff;
				`CFS_IRQ_MASK:      s_axi_rdata <= irq_mask_ff;
				`CFS_STRAP:         s_axi_rdata <= {1'b0, bus_address, 7'h0,
						loop_residual, loop_gain_value};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// straps are read once, the first cycle after reset release
	always @(posedge aclk) begin
		if (!aresetn) begin
			strap_done_ff <= 1'b0;
			st_gain_ff    <= 5'h00;
			st_uv_hi_ff   <= 1'b0;
			bus_address   <= `CFS_ADDR_OPEN;
		end else if (!strap_done_ff) begin
			strap_done_ff <= 1'b1;
			st_gain_ff    <= loop_gain_strap_code > 5'd29 ? 5'd29 : loop_gain_strap_code;
			st_uv_hi_ff   <= softstart_lockout_strap_code[3];
			if (bus_address_strap_open)
				bus_address <= `CFS_ADDR_OPEN;
			else if (bus_address_strap_gnd)
				bus_address <= `CFS_ADDR_GND;
			else if (bus_address_strap_code > 5'd30)
				bus_address <= `CFS_ADDR_MAX;
			else
				bus_address <= `CFS_ADDR_BASE + {2'b00, bus_address_strap_code};
		end
	end

	always @* begin
		nxt_state    = state_ff;
		nxt_cnt      = cnt_ff + 40'h1;
		nxt_acc      = acc_ff;
		nxt_target   = target_mv;
		nxt_up       = up_ff;
		nxt_span     = span_ff;
		nxt_cause_ov = cause_ov_ff;
		nxt_pg       = power_good_output;
		nxt_drv      = driver_enable;
		ev           = 4'h0;
		case (state_ff)
			S_OFF: begin
				nxt_pg  = 1'b0;
				nxt_drv = 1'b0;
				nxt_cnt = 40'h0;
				if (strap_done_ff && host_en && enable_in && !uv_low)
					nxt_state = S_DELAY;
			end
			S_DELAY: begin
				if (uv_low || !enable_in || !host_en) begin
					nxt_state = uv_low ? S_RETRY : S_OFF;
					nxt_cause_ov = 1'b0;
					ev[`CFS_IRQ_UV] = uv_low;
					nxt_cnt = 40'h0;
				end else if (cnt_ff + 40'h1 >= delay_n) begin
					// output is sampled as the delay runs out, before any ramp
					nxt_cnt = 40'h0;
					nxt_acc = 40'h0;
					if (ov_high) begin
						nxt_state = S_RETRY;
						nxt_cause_ov = 1'b1;
						ev[`CFS_IRQ_OV] = 1'b1;
					end else begin
						nxt_target = vout_sense_mv;
						nxt_up     = vout_sense_mv < final_mv;
						nxt_span   = final_mv - vout_sense_mv;
						nxt_drv    = 1'b1;
						nxt_state  = S_RAMP;
					end
				end
			end
			S_RAMP: begin
				// one mV step at most per cycle, so exact timing needs ramp >= delta cycles
				if (acc_ff + delta >= ramp_n) begin
					nxt_acc = acc_ff + delta - ramp_n;
					if (up_ff && target_mv != final_mv)
						nxt_target = target_mv + 16'h1;
				end else begin
					nxt_acc = acc_ff + delta;
				end
				if (cnt_ff + 40'h1 >= ramp_n) begin
					if (up_ff)
						nxt_target = final_mv;
					nxt_pg    = 1'b1;
					ev[`CFS_IRQ_PG] = 1'b1;
					nxt_state = S_ON;
				end
			end
			S_ON: begin
				if (target_mv > final_mv)
					nxt_target = target_mv - 16'h1;
				else if (target_mv < final_mv)
					nxt_target = target_mv + 16'h1;
				if (!enable_in || !host_en)
					nxt_state = S_OFF;
			end
			S_RETRY: begin
				nxt_pg  = 1'b0;
				nxt_drv = 1'b0;
				if (cnt_ff + 40'h1 >= retry_n) begin
					nxt_cnt = 40'h0;
					if (cause_ov_ff || {1'b0, vin_mv} > warn_mv) begin
						nxt_state = S_DELAY;
						ev[`CFS_IRQ_RESTART] = 1'b1;
					end
				end
			end
			S_LATCH: begin
				nxt_pg  = 1'b0;
				nxt_drv = 1'b0;
				if (!enable_in || !host_en)
					nxt_state = S_OFF;
			end
			default: nxt_state = S_OFF;
		endcase
		// faults while driving (undervoltage unless its action is ignore): shut down at the next clock edge after they are seen
		if ((state_ff == S_RAMP || state_ff == S_ON) && ov_high) begin
			nxt_pg = 1'b0;
			nxt_drv = 1'b0;
			nxt_cnt = 40'h0;
			nxt_cause_ov = 1'b1;
			ev[`CFS_IRQ_OV] = 1'b1;
			nxt_state = S_RETRY;
		end else if ((state_ff == S_RAMP || state_ff == S_ON) && uv_low &&
				uv_act_ff[1:0] != `CFS_ACT_IGNORE) begin
			nxt_pg = 1'b0;
			nxt_drv = 1'b0;
			nxt_cnt = 40'h0;
			nxt_cause_ov = 1'b0;
			ev[`CFS_IRQ_UV] = 1'b1;
			nxt_state = S_RETRY;
		end
		if (nxt_state == S_RETRY && state_ff != S_RETRY) begin
			if (member || (nxt_cause_ov ? !ov_act_ff[0] :
					uv_act_ff[1:0] != `CFS_ACT_RETRY))
				nxt_state = S_LATCH;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff          <= S_OFF;
			cnt_ff            <= 40'h0;
			acc_ff            <= 40'h0;
			up_ff             <= 1'b0;
			span_ff           <= 16'h0000;
			cause_ov_ff       <= 1'b0;
			target_mv         <= 16'h0000;
			power_good_output <= 1'b0;
			driver_enable     <= 1'b0;
			loop_gain_value   <= 10'h000;
			loop_residual     <= 7'h00;
			irq               <= 1'b0;
		end else begin
			state_ff          <= nxt_state;
			cnt_ff            <= nxt_cnt;
			acc_ff            <= nxt_acc;
			up_ff             <= nxt_up;
			span_ff           <= nxt_span;
			cause_ov_ff       <= nxt_cause_ov;
			target_mv         <= nxt_target;
			power_good_output <= nxt_pg;
			driver_enable     <= nxt_drv;
			loop_gain_value   <= gain_of(gain_idx);
			loop_residual     <= res_hi ? `CFS_RES_HI : `CFS_RES_LO;
			irq               <= |(irq_stat_ff[3:0] & irq_mask_ff[3:0]);
		end
	end
endmodule

//--- sim/cfs_plant_model.sv
`timescale 1ns/1ps
module cfs_plant_model (
	input  wire        aclk,
	input  wire        driver_enable,
	input  wire [15:0] target_mv,
	input  wire [15:0] prebias_mv,
	output wire [15:0] vout_sense_mv
);
	reg [15:0] vout_ff;
	// one cycle lag like a real stage; undriven output sits at the external prebias
	always @(posedge aclk) begin
		vout_ff <= driver_enable ? target_mv : prebias_mv;
	end
	assign vout_sense_mv = vout_ff;
endmodule

//--- sim/cfs_supervisor_asserts.sv
`timescale 1ns/1ps
module cfs_supervisor_asserts (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire [15:0] vin_mv,
	input wire [15:0] vout_sense_mv,
	input wire [4:0]  bus_address_strap_code,
	input wire        bus_address_strap_open,
	input wire        bus_address_strap_gnd,
	input wire        power_good_output,
	input wire        driver_enable,
	input wire [15:0] target_mv,
	input wire [9:0]  loop_gain_value,
	input wire [6:0]  loop_residual,
	input wire [6:0]  bus_address
);
	reg  [1:0] cnt_ff;
	wire [1:0] nxt_cnt = (cnt_ff == 2'h3) ? cnt_ff : cnt_ff + 2'h1;
	wire       strap_done = (cnt_ff == 2'h3);
	// straps must not move outside reset, so the live pins give the latched code
	wire [6:0] exp_addr = bus_address_strap_open ? 7'h28 : bus_address_strap_gnd ? 7'h26 :
		(bus_address_strap_code > 5'h1e) ? 7'h37 : 7'h19 + {2'h0, bus_address_strap_code};
	always @(posedge aclk) begin
		if (!aresetn)
			cnt_ff <= 2'h0;
		else
			cnt_ff <= nxt_cnt;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_ADDR_MAP: assert property (strap_done |-> bus_address == exp_addr)
		else $error("bus address differs from strap code");
	AST_ADDR_HOLD: assert property (strap_done && $past(strap_done) |-> $stable(bus_address))
		else $error("bus address moved after latch");
	AST_GAIN: assert property (strap_done |-> loop_gain_value inside {[10'h050:10'h320]})
		else $error("loop gain out of range");
	AST_RESID: assert property (strap_done |-> loop_residual inside {7'h5a, 7'h64})
		else $error("loop residual not 90 or 100");
	AST_PG_DRV: assert property (power_good_output |-> driver_enable)
		else $error("power good without drivers");
	AST_LOCKOUT: assert property ($rose(driver_enable) |-> vin_mv >= 16'h1054)
		else $error("drivers on below lowest lockout");
	AST_PREBIAS: assert property ($rose(driver_enable) |-> target_mv == vout_sense_mv)
		else $error("start target is not the sampled prebias");
	AST_RAMP_UP: assert property (driver_enable && !power_good_output && $past(driver_enable)
		&& !$past(power_good_output) |-> target_mv >= $past(target_mv))
		else $error("target fell during ramp");
	AST_ON_DOWN: assert property (power_good_output && $past(power_good_output)
		|-> target_mv <= $past(target_mv))
		else $error("target rose while good");
	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	cover property ($rose(power_good_output));
	cover property ($rose(driver_enable) && target_mv > 16'h03e8);
	cover property ($fell(driver_enable));
endmodule
bind cfs_supervisor cfs_supervisor_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .vin_mv, .vout_sense_mv, .bus_address_strap_code,
	.bus_address_strap_open, .bus_address_strap_gnd, .power_good_output, .driver_enable,
	.target_mv, .loop_gain_value, .loop_residual, .bus_address);

//--- sim/cfs_supervisor_tb_top.sv
`timescale 1ns/1ps
module cfs_supervisor_tb_top;
	reg         aclk = 1'b0;
	reg         aresetn = 1'b0;
	reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg         en = 1'b0, aopen = 1'b0, agnd = 1'b0;
	reg  [15:0] vin = 16'h0, prebias = 16'h0;
	reg  [4:0]  gcode = 5'h0, acode = 5'h0;
	reg  [3:0]  scode = 4'h0;
	wire        awready, wready, bvalid, arready, rvalid, pg, drv, irq;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] tgt, vout;
	wire [9:0]  gain;
	wire [6:0]  resid, addr;
	integer     errors = 0, total_checks = 0, i, n;
	reg  [31:0] rd, ex;
	reg  [1:0]  rs;
	localparam [149:0] GTAB = {10'h320, 10'h2bc, 10'h258, 10'h226, 10'h1f4, 10'h1c2, 10'h190,
		10'h168, 10'h140, 10'h118, 10'h0f0, 10'h0c8, 10'h0a0, 10'h078, 10'h050};
	always #5 aclk = ~aclk;
	cfs_supervisor #(.MS_CYCLES(10), .RETRY_CYCLES(50)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .enable_in(en), .vin_mv(vin), .vout_sense_mv(vout),
		.loop_gain_strap_code(gcode), .softstart_lockout_strap_code(scode),
		.bus_address_strap_code(acode), .bus_address_strap_open(aopen),
		.bus_address_strap_gnd(agnd), .power_good_output(pg), .driver_enable(drv),
		.target_mv(tgt), .loop_gain_value(gain), .loop_residual(resid),
		.bus_address(addr), .irq(irq));
	cfs_plant_model u_plant (.aclk(aclk), .driver_enable(drv), .target_mv(tgt),
		.prebias_mv(prebias), .vout_sense_mv(vout));
	function [31:0] addr_f(input [4:0] c, input o, input g);
		addr_f = o ? 32'h28 : g ? 32'h26 : (c > 5'h1e) ? 32'h37 : 32'h19 + {27'h0, c};
	endfunction
	function [31:0] gain_f(input [4:0] r);
		reg [4:0] k;
		begin
			k = ((r > 5'h1d) ? 5'h1d : r) % 5'h0f;
			gain_f = {22'h0, GTAB[k * 10 +: 10]};
		end
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			total_checks++;
			if (g !== e) begin
				errors++;
				$display("MISMATCH %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task rst;
		begin
			aresetn <= 1'b0;
			repeat (4) @(posedge aclk);
			aresetn <= 1'b1;
			repeat (3) @(posedge aclk);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		reg aw, w;
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			aw = 0;
			w = 0;
			while (!(aw && w)) begin
				@(posedge aclk);
				if (!aw && awready === 1'b1) begin
					aw = 1;
					awvalid <= 1'b0;
				end
				if (!w && wready === 1'b1) begin
					w = 1;
					wvalid <= 1'b0;
				end
			end
			bready <= 1'b1;
			do @(posedge aclk); while (bvalid !== 1'b1);
			bready <= 1'b0;
			chk("bresp", 32'h0, {30'h0, bresp});
		end
	endtask
	task rdr(input [7:0] a);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			do @(posedge aclk); while (arready !== 1'b1);
			arvalid <= 1'b0;
			rready <= 1'b1;
			do @(posedge aclk); while (rvalid !== 1'b1);
			rready <= 1'b0;
			rd = rdata;
			rs = rresp;
		end
	endtask
	// s picks drv, pg or target at final; n returns cycles waited
	task waitx(input integer s, input v, input integer lim);
		begin
			n = 0;
			while ((s == 0 ? drv : s == 1 ? pg : (tgt === 16'h03e8)) !== v && n < lim) begin
				@(posedge aclk);
				n++;
			end
		end
	endtask
	initial begin
		#500000;
		errors++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h6958a048));
		rst();
		rdr(8'h1c);
		chk("target reset", 32'h3e8, rd);
		rdr(8'h20);
		chk("timing reset", 32'h00050005, rd);
		rdr(8'h40);
		chk("unmapped resp", 32'h2, {30'h0, rs});
		wr(8'h08, 32'h00010100);
		rdr(8'h08);
		chk("lockout clamp", 32'h00011054, rd);
		$display("test registers done");
		for (i = 0; i < 6; i++) begin
			gcode <= (i == 0) ? 5'h1f : $urandom;
			acode <= (i == 0) ? 5'h1f : $urandom;
			scode <= $urandom;
			aopen <= (i == 1);
			agnd <= (i == 1 || i == 2);
			rst();
			chk("address", addr_f(acode, aopen, agnd), {25'h0, addr});
			chk("gain", gain_f(gcode), {22'h0, gain});
			chk("residual", (gcode > 5'h0e) ? 32'h64 : 32'h5a, {25'h0, resid});
			ex = (addr_f(acode, aopen, agnd) << 24) | gain_f(gcode);
			ex = ex | (((gcode > 5'h0e) ? 32'h64 : 32'h5a) << 10);
			rdr(8'h30);
			chk("strap readback", ex, rd);
		end
		wr(8'h04, 32'h113);
		repeat (2) @(posedge aclk);
		chk("host gain", gain_f(5'h03), {22'h0, gain});
		chk("host residual", 32'h64, {25'h0, resid});
		$display("test straps done");
		scode <= 4'h8;
		rst();
		vin <= 16'h2710;
		en <= 1'b1;
		prebias <= 16'h0190;
		wr(8'h20, 32'h00460001);
		wr(8'h00, 32'h1);
		waitx(0, 1, 200);
		chk("held below upper lockout", 32'h0, {31'h0, drv});
		vin <= 16'h2af8;
		waitx(0, 1, 100);
		chk("start above lockout", 32'h1, {31'h0, drv});
		waitx(2, 1, 900);
		chk("ramp from prebias", 32'h1, {31'h0, n >= 698 && n <= 702});
		waitx(1, 1, 5);
		chk("good after ramp", 32'h1, {31'h0, pg});
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(8'h2c, 32'h4);
		repeat (2) @(posedge aclk);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(8'h28, 32'h4);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(8'h08, 32'h00012ee0);
		waitx(0, 0, 5);
		chk("host lockout trips", 32'h0, {31'h0, drv});
		rdr(8'h24);
		chk("latched off", 32'h20, {26'h0, rd[5:0]});
		$display("test lockout and ramp done");
		scode <= 4'h0;
		prebias <= 16'h044c;
		rst();
		vin <= 16'h2ee0;
		wr(8'h20, 32'h00460001);
		wr(8'h00, 32'h1);
		waitx(0, 1, 100);
		chk("target is prebias", 32'h44c, {16'h0, tgt});
		waitx(1, 1, 800);
		chk("good at ramp end", 32'h1, {31'h0, n >= 698 && n <= 702});
		waitx(2, 1, 150);
		chk("down to target", 32'h3e8, {16'h0, tgt});
		$display("test prebias above done");
		wr(8'h00, 32'h0);
		prebias <= 16'h04b0;
		wr(8'h00, 32'h1);
		waitx(0, 1, 60);
		chk("no start over limit", 32'h0, {31'h0, drv});
		rdr(8'h24);
		chk("ov latch status", 32'h60, {25'h0, rd[11], rd[5:0]});
		rdr(8'h28);
		chk("ov event", 32'h1, {31'h0, rd[1]});
		wr(8'h18, 32'h1);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h1);
		repeat (90) @(posedge aclk);
		rdr(8'h24);
		chk("ov retry not latched", 32'h0, {31'h0, rd[5]});
		$display("test overvoltage done");
		wr(8'h18, 32'h0);
		wr(8'h00, 32'h0);
		prebias <= 16'h012c;
		wr(8'h10, 32'h1);
		wr(8'h00, 32'h1);
		waitx(1, 1, 800);
		vin <= 16'h0fa0;
		waitx(0, 0, 3);
		chk("uv shuts down", 32'h0, {31'h0, drv});
		vin <= 16'h11f8;
		repeat (120) @(posedge aclk);
		chk("no restart below warn", 32'h0, {31'h0, drv});
		vin <= 16'h1388;
		waitx(0, 1, 100);
		chk("restart above warn", 32'h1, {31'h0, drv});
		waitx(1, 1, 800);
		wr(8'h00, 32'h3);
		vin <= 16'h0fa0;
		waitx(0, 0, 3);
		rdr(8'h24);
		chk("member latches", 32'h20, {26'h0, rd[5:0]});
		$display("test undervoltage retry done");
		finish_test;
	end
endmodule
